// file: rtl/dmad_channel.sv
// dmad_channel: descriptor registers and transfer engine of one dma channel,
// with a small fifo between the source and destination sides
// assumes bus acks arrive in a cycle where the matching request is high
// Function
// - source address loaded first, tracks current transfer
// - source address steps after each source transfer
// - source step 0 up, 1 down, else fixed
// - destination address loaded, tracks each destination transfer
// - destination step 0 up, 1 down, else fixed
// - zero pointer means no list transfers
// - pointer gives next item and write-back address
// - list fetch master from list select field
// - source chaining needs enable bit and nonzero pointer
// - destination chaining needs enable bit and nonzero pointer
// - source accesses use selected bus master
// - destination accesses use selected bus master
// - transfer type codes 0..3, others reserved
// - scatter only with stepping destination address
// - gather only with stepping source address
// - source burst 1,4,8,16,32 items
// - destination burst 1,4,8,16,32 items
// - control word reloaded per block when chaining
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module dmad_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // honest flags come straight from the fill count
    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // pointers wrap on the power-of-two depth
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr] <= in_data;
    end
endmodule // dmad_fifo

module dmad_channel #(
    parameter int FIFO_DEPTH = 4,
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [dmad_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic src_req,
    output logic [31:0] src_addr,
    output logic src_bus_sel,
    output logic src_burst_end,
    input wire logic src_ack,
    input wire logic [DATA_W-1:0] src_rdata,
    output logic dst_req,
    output logic [31:0] dst_addr,
    output logic dst_bus_sel,
    output logic dst_burst_end,
    output logic [DATA_W-1:0] dst_wdata,
    input wire logic dst_ack,
    output logic list_req,
    output logic list_wb,
    output logic [31:0] list_addr,
    output logic list_bus_sel,
    output logic [31:0] list_wdata,
    input wire logic list_ack,
    input wire dmad_pkg::dmad_list_item_t list_item,
    output logic [2:0] transfer_type,
    output logic dest_spread_active,
    output logic source_collect_active,
    output logic busy
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WBACK, ST_FETCH} dmad_state_t;
    dmad_state_t state;
    dmad_state_t next_state;

    logic [31:0] sar;
    logic [31:0] dar;
    logic [31:0] llp;
    dmad_pkg::dmad_ctl_low_t ctl;
    logic [11:0] block_items;
    logic [11:0] src_left;
    logic [11:0] dst_left;
    logic [5:0] src_beat;
    logic [5:0] dst_beat;

    // register decode
    wire wr_sar = reg_wr && reg_addr == dmad_pkg::OFF_SRC_ADDR;
    wire wr_dar = reg_wr && reg_addr == dmad_pkg::OFF_DST_ADDR;
    wire wr_llp = reg_wr && reg_addr == dmad_pkg::OFF_NEXT_PTR;
    wire wr_ctl = reg_wr && reg_addr == dmad_pkg::OFF_CTL_LOW;
    wire wr_items = reg_wr && reg_addr == dmad_pkg::OFF_BLOCK_ITEMS;
    wire wr_run = reg_wr && reg_addr == dmad_pkg::OFF_RUN_CTRL;
    wire sw_ok = (state == ST_IDLE); // descriptor is frozen while the engine owns it

    // field checks; reserved codes refuse the start rather than guessing a meaning
    wire ptr_nonzero = (llp[31:dmad_pkg::PTR_LSB] != '0);
    wire src_chain_on = ctl.source_chain_enable && ptr_nonzero;
    wire dst_chain_on = ctl.dest_chain_enable && ptr_nonzero;
    wire chain_on = src_chain_on || dst_chain_on;
    wire sel_bad = ctl.source_bus_select > dmad_pkg::SEL_MASTER2 ||
        ctl.dest_bus_select > dmad_pkg::SEL_MASTER2 ||
        llp[1:0] > dmad_pkg::SEL_MASTER2;
    wire tt_bad = ctl.transfer_type > dmad_pkg::TT_PER_PER;
    wire burst_bad = ctl.source_burst_len > dmad_pkg::BURST_MAX_CODE ||
        ctl.dest_burst_len > dmad_pkg::BURST_MAX_CODE;
    wire width_bad = ctl.source_item_width > dmad_pkg::WIDTH_MAX_CODE ||
        ctl.dest_item_width > dmad_pkg::WIDTH_MAX_CODE;
    wire cfg_err = sel_bad || tt_bad || burst_bad || width_bad;
    wire start = wr_run && reg_wdata[dmad_pkg::RUN_START_BIT] && sw_ok && !cfg_err;

    function automatic logic [5:0] burst_items(input logic [2:0] code);
        case (code)
            3'h0: burst_items = dmad_pkg::BURST_1;
            3'h1: burst_items = dmad_pkg::BURST_4;
            3'h2: burst_items = dmad_pkg::BURST_8;
            3'h3: burst_items = dmad_pkg::BURST_16;
            default: burst_items = dmad_pkg::BURST_32;
        endcase
    endfunction

    function automatic logic [31:0] stepped(input logic [31:0] a, input logic [1:0] mode,
                                            input logic [2:0] width);
        logic [31:0] inc;
        inc = 32'h0000_0001 << width;
        case (mode)
            dmad_pkg::STEP_UP: stepped = a + inc;
            dmad_pkg::STEP_DOWN: stepped = a - inc;
            default: stepped = a;
        endcase
    endfunction

    // fifo between the two sides; a full fifo stalls source requests
    logic fifo_in_ready;
    logic fifo_out_valid;
    wire src_take = src_req && src_ack;
    wire dst_take = dst_req && dst_ack;
    dmad_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(src_take),
        .in_ready(fifo_in_ready),
        .in_data(src_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(dst_take),
        .out_data(dst_wdata)
    );

    // bus requests and selects
    assign src_req = (state == ST_RUN) && (src_left != '0) && fifo_in_ready;
    assign dst_req = (state == ST_RUN) && (dst_left != '0) && fifo_out_valid;
    assign src_addr = sar;
    assign dst_addr = dar;
    assign src_bus_sel = (ctl.source_bus_select == dmad_pkg::SEL_MASTER2);
    assign dst_bus_sel = (ctl.dest_bus_select == dmad_pkg::SEL_MASTER2);
    wire src_beat_last = (src_beat + 6'h01 == burst_items(ctl.source_burst_len));
    wire dst_beat_last = (dst_beat + 6'h01 == burst_items(ctl.dest_burst_len));
    assign src_burst_end = src_take && (src_beat_last || src_left == 12'h001);
    assign dst_burst_end = dst_take && (dst_beat_last || dst_left == 12'h001);

    // list item traffic: write-back and fetch both go to the pointed word
    assign list_wb = (state == ST_WBACK);
    assign list_req = (state == ST_WBACK) || (state == ST_FETCH);
    assign list_addr = {llp[31:dmad_pkg::PTR_LSB], 2'h0};
    assign list_bus_sel = (llp[1:0] == dmad_pkg::SEL_MASTER2);
    assign list_wdata = ctl;

    assign transfer_type = ctl.transfer_type;
    assign dest_spread_active = ctl.dest_spread_enable &&
        ctl.dest_addr_step inside {dmad_pkg::STEP_UP, dmad_pkg::STEP_DOWN};
    assign source_collect_active = ctl.source_collect_enable &&
        ctl.source_addr_step inside {dmad_pkg::STEP_UP, dmad_pkg::STEP_DOWN};
    assign busy = (state != ST_IDLE);
    wire block_done = (state == ST_RUN) && src_left == '0 && dst_left == '0;
    wire fetched = (state == ST_FETCH) && list_ack;

    // engine sequencing; a nonzero pointer with chaining loops through the list
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (start) next_state = ST_RUN;
            ST_RUN: if (block_done) next_state = chain_on ? ST_WBACK : ST_IDLE;
            ST_WBACK: if (list_ack) next_state = ST_FETCH;
            ST_FETCH: if (list_ack) next_state = ST_RUN;
        endcase
    end

    // status word read back on the run register
    wire [31:0] status = 32'({ptr_nonzero, source_collect_active, dest_spread_active,
        dst_chain_on, src_chain_on, cfg_err, busy});
    wire [31:0] rd_mux = (reg_addr == dmad_pkg::OFF_SRC_ADDR) ? sar :
        (reg_addr == dmad_pkg::OFF_DST_ADDR) ? dar :
        (reg_addr == dmad_pkg::OFF_NEXT_PTR) ? llp :
        (reg_addr == dmad_pkg::OFF_CTL_LOW) ? 32'(ctl) :
        (reg_addr == dmad_pkg::OFF_BLOCK_ITEMS) ? 32'(block_items) :
        (reg_addr == dmad_pkg::OFF_RUN_CTRL) ? status : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!nrst) reg_rdata <= 32'h0000_0000;
        else reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    always_ff @(posedge clk) begin
        if (!nrst) state <= ST_IDLE;
        else state <= next_state;
    end

    // source address: software load, list reload, or step per transfer
    always_ff @(posedge clk) begin
        if (!nrst) sar <= dmad_pkg::RST_SRC_ADDR;
        else if (fetched) sar <= list_item.source_addr_field;
        else if (src_take)
            sar <= stepped(sar, ctl.source_addr_step, ctl.source_item_width);
        else if (wr_sar && sw_ok) sar <= reg_wdata;
    end

    // destination address likewise
    always_ff @(posedge clk) begin
        if (!nrst) dar <= dmad_pkg::RST_DST_ADDR;
        else if (fetched) dar <= list_item.dest_addr_field;
        else if (dst_take)
            dar <= stepped(dar, ctl.dest_addr_step, ctl.dest_item_width);
        else if (wr_dar && sw_ok) dar <= reg_wdata;
    end

    // pointer and control word are part of each list item
    always_ff @(posedge clk) begin
        if (!nrst) begin
            llp <= dmad_pkg::RST_NEXT_PTR;
            ctl <= dmad_pkg::RST_CTL_LOW;
            block_items <= dmad_pkg::RST_BLOCK_ITEMS;
        end else if (fetched) begin
            llp <= list_item.next_ptr;
            ctl <= list_item.ctl & dmad_pkg::CTL_WMASK;
        end else if (sw_ok) begin
            if (wr_llp) llp <= reg_wdata;
            if (wr_ctl) ctl <= reg_wdata & dmad_pkg::CTL_WMASK;
            if (wr_items) block_items <= reg_wdata[11:0];
        end
    end

    // item counters and burst beat counters
    always_ff @(posedge clk) begin
        if (!nrst) begin
            src_left <= '0;
            dst_left <= '0;
            src_beat <= '0;
            dst_beat <= '0;
        end else if (start || fetched) begin
            src_left <= block_items;
            dst_left <= block_items;
            src_beat <= '0;
            dst_beat <= '0;
        end else begin
            if (src_take) src_left <= src_left - 12'h001;
            if (dst_take) dst_left <= dst_left - 12'h001;
            if (src_take) src_beat <= src_burst_end ? 6'h00 : src_beat + 6'h01;
            if (dst_take) dst_beat <= dst_burst_end ? 6'h00 : dst_beat + 6'h01;
        end
    end

    // checks on the engine
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_src_step_up: assert property (
        src_take && ctl.source_addr_step == dmad_pkg::STEP_UP
        |=> sar == $past(sar) + (32'h1 << $past(ctl.source_item_width)))
        else $error("source address did not step up");
    a_src_step_down: assert property (
        src_take && ctl.source_addr_step == dmad_pkg::STEP_DOWN
        |=> sar == $past(sar) - (32'h1 << $past(ctl.source_item_width)))
        else $error("source address did not step down");
    a_src_fixed_hold: assert property (
        src_take && ctl.source_addr_step[1] && !fetched |=> sar == $past(sar))
        else $error("fixed source address moved");
    a_dst_step_up: assert property (
        dst_take && ctl.dest_addr_step == dmad_pkg::STEP_UP
        |=> dar == $past(dar) + (32'h1 << $past(ctl.dest_item_width)))
        else $error("destination address did not step up");
    a_dst_fixed_hold: assert property (
        dst_take && ctl.dest_addr_step[1] && !fetched |=> dar == $past(dar))
        else $error("fixed destination address moved");
    a_zero_ptr_nolist: assert property (
        !ptr_nonzero && state == ST_RUN |-> !list_req ##1 (state != ST_WBACK))
        else $error("list traffic with zero pointer");
    // chaining is judged from the raw enable bits and pointer, not the derived wires
    a_chain_gate: assert property (
        block_done && ctl.source_chain_enable && llp[31:dmad_pkg::PTR_LSB] != '0
        |=> state == ST_WBACK)
        else $error("source chained block did not write back");
    a_done_to_wb: assert property (
        block_done && ctl.dest_chain_enable && llp[31:dmad_pkg::PTR_LSB] != '0
        |=> state == ST_WBACK)
        else $error("chained block did not write back");
    a_list_sel: assert property (list_req |-> list_bus_sel == llp[0])
        else $error("list fetch on wrong master");
    a_reload_ctl: assert property (
        fetched |=> ctl == ($past(list_item.ctl) & dmad_pkg::CTL_WMASK) && state == ST_RUN)
        else $error("control word not reloaded from list item");
    a_burst_src: assert property (
        src_take && !src_burst_end |=> src_beat == $past(src_beat) + 6'h01)
        else $error("source beat count wrong");
    a_spread_gate: assert property (ctl.dest_addr_step[1] |-> !dest_spread_active)
        else $error("scatter on fixed destination");
    a_collect_gate: assert property (ctl.source_addr_step[1] |-> !source_collect_active)
        else $error("gather on fixed source");
    a_tt_refuse: assert property (tt_bad && state == ST_IDLE |=> state == ST_IDLE)
        else $error("reserved transfer type started");

    c_single_block: cover property (start ##[1:200] (block_done && !chain_on));
    c_chain_fetch: cover property (fetched ##[1:200] block_done);
    c_fifo_full: cover property (state == ST_RUN && !fifo_in_ready);
    c_dst_burst: cover property (dst_burst_end && ctl.dest_burst_len == 3'h1);
endmodule // dmad_channel

// file: rtl/dmad_pkg.sv
// dmad_pkg: register map, control-word layout and list-item carrier for one dma channel
// assumes a single clock domain and a plain strobe register port
package dmad_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFF_SRC_ADDR = 10'h000;
    localparam logic [9:0] OFF_DST_ADDR = 10'h008;
    localparam logic [9:0] OFF_NEXT_PTR = 10'h010;
    localparam logic [9:0] OFF_CTL_LOW = 10'h018;
    localparam logic [9:0] OFF_BLOCK_ITEMS = 10'h020;
    localparam logic [9:0] OFF_RUN_CTRL = 10'h024;

    localparam logic [31:0] RST_SRC_ADDR = 32'h0000_0000;
    localparam logic [31:0] RST_DST_ADDR = 32'h0000_0000;
    localparam logic [31:0] RST_NEXT_PTR = 32'h0000_0000;
    localparam logic [31:0] RST_CTL_LOW = 32'h0030_4801;
    localparam logic [31:0] CTL_WMASK = 32'h1ff7_ffff;
    localparam logic [11:0] RST_BLOCK_ITEMS = 12'h001;

    // address step codes
    localparam logic [1:0] STEP_UP = 2'h0;
    localparam logic [1:0] STEP_DOWN = 2'h1;
    // bus master select codes
    localparam logic [1:0] SEL_MASTER1 = 2'h0;
    localparam logic [1:0] SEL_MASTER2 = 2'h1;
    // transfer type codes, all with the channel as flow controller
    localparam logic [2:0] TT_MEM_MEM = 3'h0;
    localparam logic [2:0] TT_MEM_PER = 3'h1;
    localparam logic [2:0] TT_PER_MEM = 3'h2;
    localparam logic [2:0] TT_PER_PER = 3'h3;
    // burst length codes and item counts
    localparam logic [2:0] BURST_MAX_CODE = 3'h4;
    localparam logic [5:0] BURST_1 = 6'h01;
    localparam logic [5:0] BURST_4 = 6'h04;
    localparam logic [5:0] BURST_8 = 6'h08;
    localparam logic [5:0] BURST_16 = 6'h10;
    localparam logic [5:0] BURST_32 = 6'h20;
    localparam logic [2:0] WIDTH_MAX_CODE = 3'h2;
    // pointer field sits above the two list master select bits
    localparam int PTR_LSB = 2;

    // run/status register bit positions
    localparam int RUN_START_BIT = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_CFG_ERR = 1;
    localparam int ST_SRC_CHAIN = 2;
    localparam int ST_DST_CHAIN = 3;
    localparam int ST_SPREAD = 4;
    localparam int ST_COLLECT = 5;
    localparam int ST_LIST_MODE = 6;

    typedef struct packed {
        logic [2:0] rsvd_hi;
        logic source_chain_enable;
        logic dest_chain_enable;
        logic [1:0] source_bus_select;
        logic [1:0] dest_bus_select;
        logic [2:0] transfer_type;
        logic rsvd_mid;
        logic dest_spread_enable;
        logic source_collect_enable;
        logic [2:0] source_burst_len;
        logic [2:0] dest_burst_len;
        logic [1:0] source_addr_step;
        logic [1:0] dest_addr_step;
        logic [2:0] source_item_width;
        logic [2:0] dest_item_width;
        logic int_en;
    } dmad_ctl_low_t;

    // one list item as fetched from memory
    typedef struct packed {
        logic [31:0] source_addr_field;
        logic [31:0] dest_addr_field;
        logic [31:0] next_ptr;
        dmad_ctl_low_t ctl;
    } dmad_list_item_t;
endpackage

// file: verification/dmad_far_side.sv
// dmad_far_side: memories and peripherals answering one dma channel
// assumes requests are levels held until acked; each ack is a one-cycle pulse
`timescale 1ns/1ps

module dmad_far_side (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] wait_cycles,
    input wire logic src_req,
    input wire logic [31:0] src_addr,
    output logic src_ack,
    output logic [31:0] src_rdata,
    input wire logic dst_req,
    output logic dst_ack,
    input wire logic list_req,
    input wire logic list_wb,
    output logic list_ack,
    input wire dmad_pkg::dmad_list_item_t item_in,
    output dmad_pkg::dmad_list_item_t list_item
);
    logic [2:0] req;
    logic [2:0] ack;
    logic [1:0] cnt [3];

    assign req = {list_req, dst_req, src_req};
    assign {list_ack, dst_ack, src_ack} = ack;

    // each side stalls wait_cycles before acking, so prompt and slow answers both occur
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            ack[i] <= nrst && req[i] && !ack[i] && cnt[i] >= wait_cycles;
            cnt[i] <= (!nrst || !req[i] || ack[i]) ? 2'h0 : cnt[i] + 2'(cnt[i] != 2'h3);
        end
    end

    // data means something only beside its ack; otherwise show the inverse, never stale data
    assign src_rdata = src_ack ? src_addr ^ 32'h5a5a_0000 : ~(src_addr ^ 32'h5a5a_0000);
    assign list_item = (list_ack && !list_wb) ? item_in : ~item_in;
endmodule // dmad_far_side

// file: verification/dmad_channel_bench.sv
// dmad_channel_bench: self-checking bench of one dma channel against a queue model
// assumes dmad_far_side answers the source, destination and list sides
`timescale 1ns/1ps

module dmad_channel_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [dmad_pkg::ADDR_W-1:0] reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, src_addr, src_rdata, dst_addr, dst_wdata, list_addr, list_wdata;
    logic src_req, src_bus_sel, src_burst_end, src_ack, dst_req, dst_bus_sel, dst_burst_end;
    logic dst_ack, list_req, list_wb, list_bus_sel, list_ack, busy;
    logic dest_spread_active, source_collect_active;
    logic [2:0] transfer_type;
    logic [1:0] wait_cycles = 2'h0;
    dmad_pkg::dmad_list_item_t item_in = '0;
    dmad_pkg::dmad_list_item_t list_item;
    dmad_pkg::dmad_ctl_low_t mctl, c;
    logic [31:0] exp_sar, exp_dar, mptr, ptr, rd_val;
    logic [31:0] rnd = 32'h98a8bec4;
    int num_errors = 0, tests_run = 0, nitems, s_idx, d_idx, fetches;
    logic [31:0] dq [$];
    int blen [5] = '{1, 4, 8, 16, 32};
    logic [9:0] offs [4] = '{10'h000, 10'h008, 10'h010, 10'h018};
    logic [31:0] rsts [4] = '{32'h0, 32'h0, 32'h0, 32'h0030_4801};
    logic [31:0] bad [8] = '{32'h0040_0000, 32'h0001_4000, 32'h0000_2800, 32'h0400_0000,
        32'h0100_0000, 32'h0000_0030, 32'h0000_0006, 32'h0};

    always #25 clk = ~clk;

    dmad_channel uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .src_req, .src_addr, .src_bus_sel, .src_burst_end, .src_ack, .src_rdata, .dst_req,
        .dst_addr, .dst_bus_sel, .dst_burst_end, .dst_wdata, .dst_ack, .list_req, .list_wb,
        .list_addr, .list_bus_sel, .list_wdata, .list_ack, .list_item, .transfer_type,
        .dest_spread_active, .source_collect_active, .busy);
    dmad_far_side far (.clk, .nrst, .wait_cycles, .src_req, .src_addr, .src_ack, .src_rdata,
        .dst_req, .dst_ack, .list_req, .list_wb, .list_ack, .item_in, .list_item);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction
    function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] s,
        input logic [2:0] w);
        return s == 2'h0 ? a + (32'h1 << w) : (s == 2'h1 ? a - (32'h1 << w) : a);
    endfunction

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one gap cycle after each strobe keeps a strobe from being assigned twice in a step
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // model every handshake; addresses, data and burst ends must match the prediction
    always @(posedge clk) begin
        if (nrst && src_req && src_ack) begin
            chk("src_addr", src_addr, exp_sar);
            chk("src_sel", 32'(src_bus_sel), 32'(mctl.source_bus_select == 2'h1));
            chk("src_end", 32'(src_burst_end), 32'((s_idx + 1) %
                blen[mctl.source_burst_len] == 0 || s_idx == nitems - 1));
            dq.push_back(src_rdata);
            exp_sar = step(exp_sar, mctl.source_addr_step, mctl.source_item_width);
            s_idx++;
        end
        if (nrst && dst_req && dst_ack) begin
            chk("dst_addr", dst_addr, exp_dar);
            chk("dst_sel", 32'(dst_bus_sel), 32'(mctl.dest_bus_select == 2'h1));
            chk("dst_end", 32'(dst_burst_end), 32'((d_idx + 1) %
                blen[mctl.dest_burst_len] == 0 || d_idx == nitems - 1));
            chk("dst_data", dst_wdata, dq.pop_front());
            exp_dar = step(exp_dar, mctl.dest_addr_step, mctl.dest_item_width);
            d_idx++;
        end
        if (nrst && list_req && list_ack) begin
            chk("list_addr", list_addr, {mptr[31:2], 2'h0});
            chk("list_sel", 32'(list_bus_sel), 32'(mptr[1:0] == 2'h1));
            if (list_wb)
                chk("list_wdata", list_wdata, mctl);
            else begin
                exp_sar = item_in.source_addr_field;
                exp_dar = item_in.dest_addr_field;
                mptr = item_in.next_ptr;
                mctl = item_in.ctl;
                s_idx = 0;
                d_idx = 0;
                fetches++;
            end
        end
    end

    // program one descriptor, start it and follow it to idle
    task automatic run(input logic [31:0] ctl, input logic [31:0] p, input int n);
        int expf, w;
        logic sp, co;
        expf = ctl[28] && ctl[27] && p[31:2] != 30'h0;
        rnd = lfsr(rnd);
        exp_sar = rnd;
        exp_dar = lfsr(rnd);
        wr(dmad_pkg::OFF_SRC_ADDR, exp_sar);
        wr(dmad_pkg::OFF_DST_ADDR, exp_dar);
        wr(dmad_pkg::OFF_NEXT_PTR, p);
        wr(dmad_pkg::OFF_CTL_LOW, ctl);
        wr(dmad_pkg::OFF_BLOCK_ITEMS, 32'(n));
        mctl = ctl & dmad_pkg::CTL_WMASK;
        mptr = p;
        nitems = n;
        s_idx = 0;
        d_idx = 0;
        fetches = 0;
        wait_cycles <= rnd[1:0];
        wr(dmad_pkg::OFF_RUN_CTRL, 32'h1);
        @(negedge clk);
        chk("busy", 32'(busy), 32'h1);
        chk("ttype", 32'(transfer_type), 32'(mctl.transfer_type));
        sp = mctl.dest_spread_enable && mctl.dest_addr_step < 2'h2;
        co = mctl.source_collect_enable && mctl.source_addr_step < 2'h2;
        chk("spread", 32'(dest_spread_active), 32'(sp));
        chk("collect", 32'(source_collect_active), 32'(co));
        rd(dmad_pkg::OFF_RUN_CTRL, rd_val);
        // status bits: pointer nonzero, collect, spread, dst chain, src chain
        chk("status", 32'(rd_val[6:2]),
            32'({p[31:2] != 30'h0, co, sp, 2'(expf * 3)}));
        w = 0;
        while (busy !== 1'b0 && w < 4000) begin
            @(negedge clk);
            w++;
        end
        if (w >= 4000) begin
            num_errors++;
            conclude();
        end
        chk("fetches", 32'(fetches), 32'(expf));
        chk("src_items", 32'(s_idx), 32'(n));
        chk("fifo_left", 32'(dq.size()), 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (offs[i]) begin
            rd(offs[i], rd_val);
            chk("reset_val", rd_val, rsts[i]);
            rnd = lfsr(rnd);
            wr(offs[i], rnd);
            rd(offs[i], rd_val);
            chk("readback", rd_val, i == 3 ? rnd & dmad_pkg::CTL_WMASK : rnd);
        end
        rd(10'h3fc, rd_val);
        chk("unmapped", rd_val, 32'h0);
        foreach (bad[i]) begin
            wr(dmad_pkg::OFF_NEXT_PTR, i == 7 ? 32'h2 : 32'h0);
            wr(dmad_pkg::OFF_CTL_LOW, bad[i]);
            wr(dmad_pkg::OFF_RUN_CTRL, 32'h1);
            @(negedge clk);
            chk("refused", 32'(busy), 32'h0);
        end
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(rnd);
            c = '0;
            c.source_addr_step = 2'(k % 3);
            c.dest_addr_step = 2'((k / 3) % 3);
            c.transfer_type = 3'(k % 4);
            c.source_bus_select = {1'b0, rnd[0]};
            c.dest_bus_select = {1'b0, rnd[1]};
            c.source_burst_len = 3'(rnd[4:2] % 5);
            c.dest_burst_len = 3'(rnd[7:5] % 5);
            c.source_item_width = 3'(rnd[9:8] % 3);
            c.dest_item_width = 3'(rnd[11:10] % 3);
            c.dest_spread_enable = rnd[12];
            c.source_collect_enable = rnd[13];
            c.source_chain_enable = k[0] || k >= 8;
            c.dest_chain_enable = k[0] || k >= 8;
            ptr = k >= 8 ? {rnd[31:17], 1'b1, 14'h0, 1'b0, rnd[15]} : 32'(k % 4 == 1);
            item_in.source_addr_field = lfsr(rnd ^ 32'h1);
            item_in.dest_addr_field = lfsr(rnd ^ 32'h2);
            item_in.next_ptr = 32'h0;
            item_in.ctl = c ^ 32'h0000_0180;
            run(c, ptr, 8 + int'(rnd[20:16]));
        end
        conclude();
    end
endmodule // dmad_channel_bench
